// ---- pcicg_pkg.sv ----
// Constants, command codes and field positions of the configuration cycle generator.
// Assumes a host I/O port with byte enables and one PCI cycle engine downstream.
//
// Function
// - Index register decodes at exactly CF8h only, data window across the whole doubleword CFCh-CFFh.
// - Only full doubleword writes update the index; narrower accesses go out as I/O.
// - Index bit 31 enables configuration cycles; clear means plain I/O passthrough.
// - With enable set, each data window access issues one configuration or special cycle.
// - Bus number in bits 23:16, function 10:8; software writes 30:24 zero.
// - Device field 15:11 maps one-hot onto lines 31..11; only 01h-15h usable.
// - Device value 10101b selects address line 31.
// - Index pattern all-ones device and function, register 0, on own bus makes data write a special cycle.
// - Own bus 00h gives Type 0 translation, any other bus Type 1.
// - Halt and shutdown special cycles are issued on hardware request.
// - Type 1 copies index bits 23:2 onto the address lines with upper byte zero and low bits 01.
// - Bits 7:2 pick the doubleword register; bits 1:0 written 00 by software.
package pcicg_pkg;
  // ****************************************
  // Decode and layout
  // ****************************************
  localparam logic [15:0] IDX_ADDR    = 16'h0CF8;
  localparam logic [15:0] DATA_ADDR   = 16'h0CFC;
  localparam logic [3:0]  BE_FULL     = 4'hF;
  localparam int          EN_BIT      = 31;
  localparam int          BUS_HI      = 23;
  localparam int          BUS_LO      = 16;
  localparam int          DEV_HI      = 15;
  localparam int          DEV_LO      = 11;
  localparam int          FN_HI       = 10;
  localparam int          FN_LO       = 8;
  localparam int          REG_HI      = 7;
  localparam int          REG_LO      = 2;
  localparam logic [31:0] IDX_RESET   = 32'h0000_0000;
  localparam logic [7:0]  OWN_BUS     = 8'h00;
  localparam logic [4:0]  DEV_FIRST   = 5'h01;
  localparam logic [4:0]  DEV_LAST    = 5'h15;
  localparam int          SEL_LINES   = 21;
  localparam logic [7:0]  SPEC_DEVFN  = 8'hFF;
  localparam logic [5:0]  SPEC_REG    = 6'h00;
  localparam logic [1:0]  TYPE0_CODE  = 2'b00;
  localparam logic [1:0]  TYPE1_CODE  = 2'b01;
  // ****************************************
  // PCI commands and fixed messages
  // ****************************************
  localparam logic [3:0]  CMD_SPECIAL = 4'h1;
  localparam logic [3:0]  CMD_IO_RD   = 4'h2;
  localparam logic [3:0]  CMD_IO_WR   = 4'h3;
  localparam logic [3:0]  CMD_CFG_RD  = 4'hA;
  localparam logic [3:0]  CMD_CFG_WR  = 4'hB;
  localparam logic [31:0] MSG_SHUT    = 32'h0000_0000;
  localparam logic [31:0] MSG_HALT    = 32'h0000_0001;
  typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_ACK} pcicg_state_e;
endpackage

// ---- pcicg_top.sv ----
// Configuration cycle generator: host I/O decode, index register and PCI cycle issue.
// Assumes the host waits for IO_ACK before a new request and the PCI engine pulses PCI_DONE.
`timescale 1ns/1ps
module pcicg_top (
  input  wire logic                MCLK,
  input  wire logic                RESET_N,
  input  wire logic                IO_REQ,
  input  wire logic                IO_WR,
  input  wire logic [15:0]         IO_ADDR,
  input  wire logic [3:0]          IO_BE,
  input  wire logic [31:0]         IO_WDATA,
  output logic                     IO_ACK,
  output logic [31:0]              IO_RDATA,
  input  wire logic                HALT_REQ,
  input  wire logic                SHUT_REQ,
  output logic                     PCI_REQ,
  output logic [3:0]               PCI_CMD,
  output logic [31:0]              PCI_ADDR,
  output logic [3:0]               PCI_BE,
  output logic [31:0]              PCI_WDATA,
  input  wire logic                PCI_DONE,
  input  wire logic [31:0]         PCI_RDATA,
  output logic [31:0]              CFG_INDEX
);
  import pcicg_pkg::*;

  // ****************************************
  // State
  // ****************************************
  pcicg_state_e state;
  logic [31:0]  config_index_register;
  logic         halt_pend;
  logic         shut_pend;
  logic         host_cycle;

  // Assertions below share the system clock and stay quiet during reset
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // ****************************************
  // Decode
  // ****************************************
  // Index fields of the current index register
  wire          config_cycle_enable = config_index_register[EN_BIT];
  wire [7:0]    bus_num = config_index_register[BUS_HI:BUS_LO];
  wire [4:0]    dev_num = config_index_register[DEV_HI:DEV_LO];
  wire [7:0]    devfn   = config_index_register[DEV_HI:FN_LO];
  wire [5:0]    reg_num = config_index_register[REG_HI:REG_LO];
  // Host access classification
  wire          take     = IO_REQ && state == ST_IDLE && !halt_pend && !shut_pend;
  wire          idx_at   = IO_ADDR == IDX_ADDR;
  wire          idx_full = idx_at && IO_BE == BE_FULL;
  wire          data_at  = IO_ADDR[15:2] == DATA_ADDR[15:2];
  wire          cfg_go   = data_at && config_cycle_enable;
  wire          own_bus  = bus_num == OWN_BUS;
  wire          spec_go  = cfg_go && IO_WR && own_bus && devfn == SPEC_DEVFN
                           && reg_num == SPEC_REG;
  // One-hot device select; values outside 01h..15h select no line
  wire          dev_ok   = dev_num >= DEV_FIRST && dev_num <= DEV_LAST;
  wire [4:0]    dev_off  = dev_num - DEV_FIRST;
  wire [SEL_LINES-1:0] dev_sel = dev_ok ? (SEL_LINES'(1) << dev_off) : '0;
  wire [31:0]   type0_addr = {dev_sel, config_index_register[FN_HI:REG_LO], TYPE0_CODE};
  // Upper byte is zeroed so the enable bit never reaches the far bridge
  wire [31:0]   type1_addr = {8'h00, config_index_register[BUS_HI:REG_LO], TYPE1_CODE};
  // Cycle chosen for a taken host request
  wire [3:0]    host_cmd = spec_go ? CMD_SPECIAL :
                           cfg_go  ? (IO_WR ? CMD_CFG_WR : CMD_CFG_RD) :
                                     (IO_WR ? CMD_IO_WR : CMD_IO_RD);
  wire [31:0]   host_addr = spec_go ? 32'h0000_0000 :
                            cfg_go  ? (own_bus ? type0_addr : type1_addr) :
                                      {16'h0000, IO_ADDR};
  wire          local_hit = idx_full;

  // ****************************************
  // Index register
  // ****************************************
  // Narrow accesses never touch it, so byte I/O devices can share the port
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      config_index_register <= IDX_RESET;
    end else if (take && idx_full && IO_WR) begin
      config_index_register <= IO_WDATA;
    end
  end

  // A dword index read answers with the stored value, then acknowledges
  idx_read_a: assert property (
      take && idx_full && !IO_WR |=> IO_RDATA == $past(config_index_register) ##1 IO_ACK)
    else $error("index read not answered");

  // Pending fixed messages; a new request wins over the clear
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      halt_pend <= 1'b0;
      shut_pend <= 1'b0;
    end else begin
      halt_pend <= HALT_REQ || (halt_pend && !(state == ST_IDLE && !shut_pend));
      shut_pend <= SHUT_REQ || (shut_pend && state != ST_IDLE);
    end
  end

  // Shutdown leaves first, as a full-width broadcast with no address
  shut_msg_a: assert property (state == ST_IDLE && shut_pend |=> PCI_REQ && PCI_CMD == CMD_SPECIAL
      && PCI_WDATA == MSG_SHUT && PCI_BE == BE_FULL && PCI_ADDR == '0)
    else $error("shutdown message not issued");
  // A request pulse is kept even when it meets the clear
  halt_keep_a: assert property (HALT_REQ |=> halt_pend)
    else $error("halt request lost");
  shut_keep_a: assert property (SHUT_REQ |=> shut_pend)
    else $error("shutdown request lost");

  // ****************************************
  // Cycle sequencer
  // ****************************************
  // Fixed messages go first; shutdown outranks halt
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= ST_IDLE;
      host_cycle <= 1'b0;
      PCI_REQ    <= 1'b0;
      PCI_CMD    <= CMD_IO_RD;
      PCI_ADDR   <= '0;
      PCI_BE     <= '0;
      PCI_WDATA  <= '0;
      IO_ACK     <= 1'b0;
      IO_RDATA   <= '0;
    end else begin
      IO_ACK <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (shut_pend || halt_pend) begin
            state      <= ST_BUS;
            host_cycle <= 1'b0;
            PCI_REQ    <= 1'b1;
            PCI_CMD    <= CMD_SPECIAL;
            PCI_ADDR   <= '0;
            PCI_BE     <= BE_FULL;
            PCI_WDATA  <= shut_pend ? MSG_SHUT : MSG_HALT;
          end else if (take && local_hit) begin
            state    <= ST_ACK;
            IO_RDATA <= config_index_register;
          end else if (take) begin
            state      <= ST_BUS;
            host_cycle <= 1'b1;
            PCI_REQ    <= 1'b1;
            PCI_CMD    <= host_cmd;
            PCI_ADDR   <= host_addr;
            PCI_BE     <= IO_BE;
            PCI_WDATA  <= IO_WDATA;
          end
        end
        ST_BUS: begin
          if (PCI_DONE) begin
            PCI_REQ  <= 1'b0;
            IO_RDATA <= PCI_RDATA;
            state    <= host_cycle ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          IO_ACK <= 1'b1;
          state  <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // The far side may take any time, so the request must stand still until it answers
  pci_hold_a: assert property (PCI_REQ && !PCI_DONE |=> PCI_REQ && $stable(PCI_CMD) && $stable(PCI_ADDR)
      && $stable(PCI_BE) && $stable(PCI_WDATA))
    else $error("far side request changed early");
  // Host byte enables travel unchanged with every forwarded access
  be_pass_a: assert property (take && !local_hit |=> PCI_REQ && PCI_BE == $past(IO_BE))
    else $error("byte enables not passed");
  // Pending fixed messages go out before any host cycle
  fixed_first_a: assert property (state == ST_IDLE && (halt_pend || shut_pend) |=> PCI_REQ && !host_cycle)
    else $error("fixed message not first");

  // Index copy for observation
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CFG_INDEX <= IDX_RESET;
    end else begin
      CFG_INDEX <= config_index_register;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  idx_write_a: assert property (take && idx_full && IO_WR |=> config_index_register == $past(IO_WDATA))
    else $error("index not loaded by dword write");
  idx_narrow_a: assert property (take && idx_at && !idx_full && IO_WR |=> $stable(config_index_register)
      && PCI_REQ && PCI_CMD == CMD_IO_WR)
    else $error("narrow index write not forwarded");
  cfg_gate_a: assert property (take && data_at && !config_cycle_enable && !IO_WR |=> PCI_CMD == CMD_IO_RD)
    else $error("disabled data access not plain I/O");
  cfg_issue_a: assert property (take && cfg_go && !spec_go |=> PCI_REQ
      && (PCI_CMD == CMD_CFG_RD || PCI_CMD == CMD_CFG_WR))
    else $error("config cycle not issued");
  type0_addr_a: assert property (take && cfg_go && !spec_go && own_bus |=> PCI_ADDR[1:0] == TYPE0_CODE
      && PCI_ADDR[FN_HI:REG_LO] == $past(config_index_register[FN_HI:REG_LO])
      && $countones(PCI_ADDR[31:11]) == ($past(dev_ok) ? 1 : 0))
    else $error("type 0 address wrong");
  // Devices outside the usable range select no line; the cycle still goes out
  dev_none_a: assert property (take && cfg_go && !spec_go && own_bus && !dev_ok |=> PCI_ADDR[31:11] == '0)
    else $error("unusable device selected a line");
  dev_top_a: assert property (take && cfg_go && own_bus && dev_num == DEV_LAST |=> PCI_ADDR[31])
    else $error("device 21 not on line 31");
  type1_addr_a: assert property (take && cfg_go && !own_bus |=> PCI_ADDR[1:0] == TYPE1_CODE
      && PCI_ADDR[BUS_HI:REG_LO] == $past(config_index_register[BUS_HI:REG_LO]))
    else $error("type 1 address wrong");
  // Upper byte stays clear so a far bridge never sees the enable bit
  type1_top_a: assert property (take && cfg_go && !own_bus |=> PCI_ADDR[31:24] == '0)
    else $error("type 1 upper byte not clear");
  special_a: assert property (take && spec_go |=> PCI_CMD == CMD_SPECIAL && PCI_WDATA == $past(IO_WDATA))
    else $error("software special cycle wrong");
  // A broadcast has no target, so its address phase carries zero
  spec_addr_a: assert property (take && spec_go |=> PCI_ADDR == '0)
    else $error("special cycle address not zero");
  halt_msg_a: assert property (state == ST_IDLE && halt_pend && !shut_pend |=> PCI_REQ
      && PCI_CMD == CMD_SPECIAL && PCI_WDATA == MSG_HALT)
    else $error("halt message not issued");
  ack_after_a: assert property (state == ST_BUS && PCI_DONE && host_cycle |=> ##1 IO_ACK)
    else $error("host not answered");
endmodule

// ---- pcicg_pci_model.sv ----
// PCI engine model standing behind the configuration cycle generator.
// Assumes PCI_REQ is held until PCI_DONE is seen; answers after lat cycles.
`timescale 1ns/1ps
module pcicg_pci_model (
  input  wire logic        MCLK,
  input  wire logic        PCI_REQ,
  input  wire logic [3:0]  PCI_CMD,
  input  wire logic [31:0] PCI_ADDR,
  input  wire logic [3:0]  PCI_BE,
  input  wire logic [31:0] PCI_WDATA,
  input  wire logic [3:0]  lat,
  output logic             PCI_DONE,
  output logic [31:0]      PCI_RDATA,
  output logic [3:0]       cap_cmd,
  output logic [3:0]       cap_be,
  output logic [31:0]      cap_addr,
  output logic [31:0]      cap_wdata,
  output int               n_done
);
  // ****************************************
  // Cycle completion
  // ****************************************
  int cnt;
  initial begin
    PCI_DONE = 0;
    PCI_RDATA = 32'h0000_0000;
    n_done = 0;
    cnt = 0;
  end
  // Read data is only valid with done; after done and while idle it churns so stale values never match
  always @(posedge MCLK) begin
    #1;
    if (PCI_DONE) begin
      PCI_DONE = 0;
      PCI_RDATA = ~PCI_RDATA;
    end else if (PCI_REQ && cnt >= int'(lat)) begin
      PCI_DONE = 1;
      PCI_RDATA = ~PCI_ADDR;
      cap_cmd = PCI_CMD;
      cap_be = PCI_BE;
      cap_addr = PCI_ADDR;
      cap_wdata = PCI_WDATA;
      n_done++;
      cnt = 0;
    end else if (PCI_REQ) begin
      cnt++;
    end else begin
      PCI_RDATA = PCI_RDATA + 32'h1357_9BDF;
    end
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the configuration cycle generator.
// Assumes the host waits for IO_ACK and the PCI model answers every cycle.
`timescale 1ns/1ps
module tb;
  import pcicg_pkg::*;
  logic        MCLK, RESET_N, IO_REQ, IO_WR, HALT_REQ, SHUT_REQ, IO_ACK, PCI_REQ, PCI_DONE;
  logic [15:0] IO_ADDR;
  logic [3:0]  IO_BE, PCI_CMD, PCI_BE, cap_cmd, cap_be, lat;
  logic [31:0] IO_WDATA, IO_RDATA, PCI_ADDR, PCI_WDATA, PCI_RDATA, CFG_INDEX, cap_addr, cap_wdata, rd;
  int          err_count, checks_done, n_done;
  pcicg_top dut_u (.*);
  pcicg_pci_model pci_u (.*);
  // ****************************************
  // Shared tasks
  // ****************************************
  initial begin
    MCLK = 0;
    forever #5 MCLK = ~MCLK;
  end
  function automatic logic [31:0] ix(logic en, logic [7:0] b, logic [4:0] d, logic [2:0] f, logic [5:0] r);
    return {en, 7'h00, b, d, f, r, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle request pulse, then a bounded wait for the acknowledge
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd);
    int n;
    @(posedge MCLK);
    #1 IO_REQ = 1;
    IO_WR = w;
    IO_ADDR = a;
    IO_BE = be;
    IO_WDATA = wd;
    @(posedge MCLK);
    #1 IO_REQ = 0;
    n = 0;
    while (IO_ACK !== 1'b1 && n < 60) begin
      @(posedge MCLK);
      #1 n++;
    end
    if (n >= 60) chk(32'h0000_0000, 32'hFFFF_FFFF);
    rd = IO_RDATA;
  endtask
  task automatic xfer(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd,
                      input logic [3:0] ec);
    int n0;
    n0 = n_done;
    io(w, a, be, wd);
    chk(n_done, n0 + 1);
    chk({28'h0, cap_cmd}, {28'h0, ec});
    chk({28'h0, cap_be}, {28'h0, be});
  endtask
  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (n_done < n && k < 100) begin
      @(posedge MCLK);
      k++;
    end
    chk(n_done, n);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_index;
    io(0, IDX_ADDR, BE_FULL, 0);
    chk(rd, IDX_RESET);
    io(1, IDX_ADDR, BE_FULL, 32'h80A5_5AFC);
    io(0, IDX_ADDR, BE_FULL, 0);
    chk(rd, 32'h80A5_5AFC);
    chk(CFG_INDEX, 32'h80A5_5AFC);
  endtask
  // Narrow index accesses go out as plain I/O and leave the index alone
  task automatic t_narrow;
    xfer(1, IDX_ADDR, 4'h3, 32'h0000_1234, CMD_IO_WR);
    chk(CFG_INDEX, 32'h80A5_5AFC);
    xfer(0, IDX_ADDR, 4'h1, 0, CMD_IO_RD);
    chk(cap_addr, {16'h0000, IDX_ADDR});
    chk(CFG_INDEX, 32'h80A5_5AFC);
    io(1, IDX_ADDR, BE_FULL, ix(0, 8'h00, 5'h01, 3'h0, 6'h01));
    xfer(0, DATA_ADDR, BE_FULL, 0, CMD_IO_RD);
    chk(cap_addr, {16'h0000, DATA_ADDR});
  endtask
  // Highest select line, then the lowest one with a slow far side
  task automatic t_type0;
    io(1, IDX_ADDR, BE_FULL, ix(1, OWN_BUS, DEV_LAST, 3'h5, 6'h03));
    xfer(0, DATA_ADDR, BE_FULL, 0, CMD_CFG_RD);
    chk(cap_addr, {21'h10_0000, 3'h5, 6'h03, TYPE0_CODE});
    chk(rd, ~cap_addr);
    lat = 4'h3;
    io(1, IDX_ADDR, BE_FULL, ix(1, OWN_BUS, DEV_FIRST, 3'h2, 6'h3F));
    xfer(1, DATA_ADDR, 4'h6, 32'h1111_2222, CMD_CFG_WR);
    chk(cap_addr, {21'h00_0001, 3'h2, 6'h3F, TYPE0_CODE});
    chk(cap_wdata, 32'h1111_2222);
    lat = 4'h0;
  endtask
  task automatic t_type1;
    io(1, IDX_ADDR, BE_FULL, ix(1, 8'h05, 5'h03, 3'h2, 6'h04));
    xfer(1, DATA_ADDR, BE_FULL, 32'h0000_00AA, CMD_CFG_WR);
    chk(cap_addr, {8'h00, 8'h05, 5'h03, 3'h2, 6'h04, TYPE1_CODE});
    chk(cap_wdata, 32'h0000_00AA);
    xfer(0, DATA_ADDR + 16'h0002, 4'hC, 0, CMD_CFG_RD);
    chk(cap_addr, {8'h00, 8'h05, 5'h03, 3'h2, 6'h04, TYPE1_CODE});
    chk(rd, ~cap_addr);
  endtask
  task automatic t_special;
    io(1, IDX_ADDR, BE_FULL, {1'b1, 7'h00, OWN_BUS, SPEC_DEVFN, SPEC_REG, 2'b00});
    xfer(1, DATA_ADDR, BE_FULL, 32'hDEAD_BEEF, CMD_SPECIAL);
    chk(cap_addr, 32'h0000_0000);
    chk(cap_wdata, 32'hDEAD_BEEF);
    // The same pattern read is an ordinary config read, and device 1Fh selects no line
    xfer(0, DATA_ADDR, BE_FULL, 0, CMD_CFG_RD);
    chk(cap_addr, 32'h0000_0700);
  endtask
  // Both fixed messages at once: shutdown must go first
  task automatic t_fixed;
    int n0;
    n0 = n_done;
    @(posedge MCLK);
    #1 HALT_REQ = 1;
    SHUT_REQ = 1;
    @(posedge MCLK);
    #1 HALT_REQ = 0;
    SHUT_REQ = 0;
    wait_done(n0 + 1);
    chk(cap_wdata, MSG_SHUT);
    chk({28'h0, cap_cmd}, {28'h0, CMD_SPECIAL});
    chk({28'h0, cap_be}, {28'h0, BE_FULL});
    chk(cap_addr, 32'h0000_0000);
    wait_done(n0 + 2);
    chk(cap_wdata, MSG_HALT);
    chk({28'h0, cap_cmd}, {28'h0, CMD_SPECIAL});
    chk({28'h0, cap_be}, {28'h0, BE_FULL});
  endtask
  task automatic summarize;
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    {err_count, checks_done, lat, IO_REQ, IO_WR, IO_ADDR, IO_BE, IO_WDATA, HALT_REQ, SHUT_REQ} = '0;
    RESET_N = 0;
    repeat (2) @(posedge MCLK);
    #1 RESET_N = 1;
    t_index();
    t_narrow();
    t_type0();
    t_type1();
    t_special();
    t_fixed();
    summarize();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #50000;
    err_count++;
    summarize();
  end
endmodule
